/* File: wcfgt_partner.sv */
// Far side model: water level, drain level, chemical supplier
`timescale 1ns/1ps
`default_nettype none
module wcfgt_partner (
  // Machine outputs seen
  input  wire logic        clk_i,
  input  wire logic        valve_i,
  input  wire logic        drain_i,
  input  wire logic        chem1_i,
  // Speed of the far side, zero fill delay never fills
  input  wire logic [15:0] fill_dly_i,
  input  wire logic [15:0] drain_dly_i,
  // Levels and decoded pulse
  output logic             level_ok_o,
  output logic             low_level_o,
  output logic [15:0]      chem1_len_o
);
  logic [15:0] fc = 16'h0, dc = 16'h0, cc = 16'h0;
  always @(posedge clk_i) begin
    fc <= valve_i ? fc + 16'h1 : 16'h0;
    dc <= drain_i ? dc + 16'h1 : 16'h0;
    cc <= chem1_i ? cc + 16'h1 : 16'h0;
    if (!chem1_i && cc != 16'h0) chem1_len_o <= cc;
  end
  assign level_ok_o  = fill_dly_i != 16'h0 && fc >= fill_dly_i;
  assign low_level_o = dc < drain_dly_i;
endmodule : wcfgt_partner
`default_nettype wire

/* File: wcfgt_pkg.sv */
// Constants, register map and state codes for the washer timing block
`default_nettype none
package wcfgt_pkg;
  // Clock and one-second tick
  localparam int unsigned CLK_HZ   = 250000000;
  localparam int unsigned TICK_S   = 1;
  localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
  // Register byte offsets
  localparam logic [7:0] A_CFG   = 8'h00;
  localparam logic [7:0] A_DRAIN = 8'h04;
  localparam logic [7:0] A_FILLT = 8'h08;
  localparam logic [7:0] A_FORM  = 8'h0C;
  localparam logic [7:0] A_CSEL  = 8'h10;
  localparam logic [7:0] A_CTIM  = 8'h14;
  localparam logic [7:0] A_CMD   = 8'h18;
  localparam logic [7:0] A_STS   = 8'h1C;
  localparam logic [7:0] A_MSK   = 8'h20;
  localparam logic [7:0] A_STATE = 8'h24;
  localparam logic [7:0] A_VALID = 8'h28;
  localparam logic [7:0] A_RSTR  = 8'h2C;
  // Field positions
  localparam int CFG_SPLIT = 4;
  localparam int C_DRAIN   = 0;
  localparam int C_STOPD   = 1;
  localparam int C_FILL    = 2;
  localparam int C_STOPF   = 3;
  localparam int C_TEMP    = 4;
  localparam int C_FIN     = 6;
  localparam int C_CHEM    = 8;
  // Status bits
  localparam int S_DERR  = 0;
  localparam int S_FTMO  = 1;
  localparam int S_FLONG = 2;
  localparam int S_FDONE = 3;
  localparam int S_XTR   = 4;
  localparam int S_FLUSH = 5;
  localparam int S_RSTR  = 6;
  localparam int NSTS    = 7;
  // Ranges, limits and times in seconds
  localparam logic [2:0]  LANG_MAX   = 3'h6;
  localparam logic [7:0]  DRAIN_MIN  = 8'h1E;
  localparam logic [4:0]  FILLT_MAX  = 5'h14;
  localparam logic [10:0] FILL_ZERO_S = 11'h258;
  localparam logic [7:0]  CHEM_FIX_S = 8'h1E;
  localparam logic [7:0]  CHEM1_DFLT = 8'h1E;
  localparam logic [7:0]  FLUSH_DLY_S = 8'h14;
  localparam logic [7:0]  FLUSH_ON_S = 8'h1E;
  localparam int          N_FORM     = 30;
  localparam int          N_DFLT     = 10;
  // Reset values
  localparam logic [2:0] LANG_RST  = 3'h0;
  localparam logic [7:0] DRAIN_RST = 8'h3C;
  localparam logic [4:0] FILLT_RST = 5'h05;
  // Temperature codes
  localparam logic [1:0] T_COLD  = 2'h2;
  localparam logic [1:0] T_SPLIT = 2'h3;
  // Sequencer states
  typedef enum logic [1:0] {
    F_IDLE = 2'b00, F_RUN = 2'b01, F_ERR = 2'b10
  } wcfgt_fill_t;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00, D_WAIT = 2'b01, D_XTR = 2'b10
  } wcfgt_drain_t;
  typedef enum logic [1:0] {
    L_IDLE = 2'b00, L_DLY = 2'b01, L_ON = 2'b10
  } wcfgt_flush_t;
endpackage : wcfgt_pkg
`default_nettype wire

/* File: wcfgt_properties.sv */
// Port-level assertions for the washer timing block
`timescale 1ns/1ps
`default_nettype none
module wcfgt_properties #(
  parameter int unsigned TICK_CYC = 10
) (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  // Bus handshake
  input wire logic       read_i,
  input wire logic       write_i,
  input wire logic       waitrequest_o,
  // Machine signals
  input wire logic       level_ok_i,
  input wire logic       op_ack_i,
  input wire logic [2:0] lang_o,
  input wire logic       drain_o,
  input wire logic       extract_o,
  input wire logic       drain_err_o,
  input wire logic       alert_o,
  input wire logic [4:0] chem_o,
  input wire logic       flush_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_LANG: assert property (lang_o <= 3'h6)
    else $error("language code above six");
  AST_WAIT: assert property ((read_i || write_i) && waitrequest_o
    |=> !waitrequest_o) else $error("no answer after one wait");
  AST_WAIT_ONE: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("answer held too long");
  AST_EXTR: assert property ($rose(extract_o)
    |-> drain_o && $past(drain_o, 8))
    else $error("extract without drain delay");
  AST_DERR: assert property ($rose(drain_err_o) |-> extract_o)
    else $error("drain error before delay expired");
  AST_ACK: assert property (alert_o && op_ack_i |=> !alert_o)
    else $error("alert kept after acknowledge");
  AST_CHEM: assert property ($rose(|chem_o) |-> $past(level_ok_i))
    else $error("chemicals without level");
  AST_FLUSH: assert property ($rose(flush_o) |-> chem_o == 5'h00)
    else $error("flush during injection");
  AST_QUIET: assert property ($fell(|chem_o) |=> !flush_o [*8])
    else $error("flush too soon after injection");
  cover property ($rose(extract_o));
  cover property ($rose(alert_o));
  cover property ($fell(flush_o));
endmodule : wcfgt_properties
bind wcfgt_top wcfgt_properties #(.TICK_CYC(TICK_CYC)) chk_i (
  .ref_clk_i, .arst_n_i, .read_i, .write_i, .waitrequest_o, .level_ok_i,
  .op_ack_i, .lang_o, .drain_o, .extract_o, .drain_err_o, .alert_o,
  .chem_o, .flush_o);
`default_nettype wire

/* File: wcfgt_tb.sv */
// Self-checking bench for the washer timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk_i, arst_n_i, read_i, write_i, op_ack_i, level_ok_i;
  logic        low_level_i, waitrequest_o, hot_valve_o, cold_valve_o;
  logic        drain_o, extract_o, drain_err_o, alert_o, flush_o, irq_o;
  logic [7:0]  address_i;
  logic [31:0] writedata_i, readdata_o, rd;
  logic [2:0]  lang_o;
  logic [4:0]  chem_o;
  logic [15:0] fdly, ddly, clen;
  int          bad_count, checks, n, t, m_lang;
  wcfgt_top #(.TICK_CYC(10)) dut (.ref_clk_i, .arst_n_i, .ce_i(1'b1),
    .address_i, .read_i, .write_i, .writedata_i, .readdata_o,
    .waitrequest_o, .low_level_i, .level_ok_i, .op_ack_i, .lang_o,
    .hot_valve_o, .cold_valve_o, .drain_o, .extract_o, .drain_err_o,
    .alert_o, .chem_o, .flush_o, .irq_o);
  wcfgt_partner far (.clk_i(ref_clk_i), .valve_i(hot_valve_o | cold_valve_o),
    .drain_i(drain_o), .chem1_i(chem_o[0]), .fill_dly_i(fdly),
    .drain_dly_i(ddly), .level_ok_o(level_ok_i), .low_level_o(low_level_i),
    .chem1_len_o(clen));
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One bus access; request held until waitrequest sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d = 32'h0);
    address_i <= a; read_i <= !w; write_i <= w; writedata_i <= d;
    do @(posedge ref_clk_i); while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    read_i <= 1'b0; write_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask : bus
  function automatic logic pick(input int s);
    logic [7:0] b;
    b = {irq_o, flush_o, alert_o, extract_o, chem_o[1:0], cold_valve_o, 1'b0};
    return b[s];
  endfunction : pick
  // Bounded by the watchdog
  task automatic wt(input int s, input logic v);
    n = 0;
    while (pick(s) !== v) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask : wt
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    conclude();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n_i = 1'b0; read_i = 1'b0; write_i = 1'b0; op_ack_i = 1'b0;
    address_i = 8'h00; writedata_i = 32'h0; fdly = 16'h0; ddly = 16'h7D0;
    bad_count = 0; checks = 0; m_lang = 0;
    void'($urandom(32'hE69A));
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int v = 0; v < 8; v++) begin
      bus(1'b1, 8'h00, 32'(v));
      if (v <= 6) m_lang = v;
      chk(32'(lang_o), 32'(m_lang));
    end
    $display("test language done");
    // Drain: refused values, then low level never clears
    bus(1'b0, 8'h04);
    chk(rd, 32'h3C);
    bus(1'b1, 8'h04, 32'h1D);
    bus(1'b1, 8'h04, 32'h100);
    bus(1'b0, 8'h04);
    chk(rd, 32'h3C);
    bus(1'b1, 8'h04, 32'h1E);
    bus(1'b1, 8'h20, 32'h11);
    bus(1'b1, 8'h18, 32'h1);
    wt(4, 1'b1);
    chk(32'(n inside {[285:305]}), 32'h1);
    chk(32'(drain_err_o), 32'h1);
    wt(7, 1'b1);
    bus(1'b0, 8'h1C);
    chk(rd & 32'h11, 32'h11);
    chk(32'(irq_o), 32'h0);
    bus(1'b1, 8'h18, 32'h2);
    $display("test drain done");
    // Fill timeout, acknowledge, then all chemicals
    t = $urandom_range(9, 2);
    bus(1'b1, 8'h08, 32'h15);
    bus(1'b0, 8'h08);
    chk(rd, 32'h5);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h14, 32'(t));
    bus(1'b1, 8'h0C, 32'h3);
    bus(1'b1, 8'h18, 32'h1F24);
    wt(5, 1'b1);
    chk(32'(n inside {[585:605]}), 32'h1);
    chk({irq_o, cold_valve_o}, 32'h0);
    fdly <= 16'h64;
    op_ack_i <= 1'b1;
    @(posedge ref_clk_i);
    op_ack_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk({alert_o, cold_valve_o}, 32'h1);
    wt(2, 1'b1);
    chk(32'(chem_o), 32'h1F);
    wt(3, 1'b0);
    chk(n, 300);
    chk(32'(clen), 32'(10 * t));
    wt(6, 1'b1);
    chk(32'(n inside {[188:203]}), 32'h1);
    wt(6, 1'b0);
    chk(32'(n inside {[291:301]}), 32'h1);
    $display("test chemicals done");
    // Split finish fill with zero timeout: alert late, valves stay open
    fdly <= 16'h0;
    bus(1'b1, 8'h00, 32'h10);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h18, 32'h44);
    chk({hot_valve_o, cold_valve_o}, 32'h3);
    wt(5, 1'b1);
    chk(32'(n inside {[5985:6005]}), 32'h1);
    chk({hot_valve_o, cold_valve_o}, 32'h3);
    bus(1'b1, 8'h18, 32'h8);
    $display("test split fill done");
    // Restore options, formula 21 keeps its valid flag under option 1 only, never its user time
    bus(1'b0, 8'h1C);
    bus(1'b1, 8'h20, 32'h40);
    bus(1'b1, 8'h10, 32'h14);
    bus(1'b1, 8'h14, 32'h7);
    for (int o = 1; o >= 0; o--) begin
      bus(1'b1, 8'h2C, 32'(o));
      wt(7, 1'b1);
      bus(1'b0, 8'h1C);
      bus(1'b0, 8'h28);
      chk(rd, o ? 32'h1003FF : 32'h3FF);
      bus(1'b0, 8'h14);
      chk(rd, 32'h1E);
    end
    bus(1'b0, 8'h3C);
    chk(rd, 32'h0);
    $display("test restore done");
    conclude();
  end
endmodule : testbench
`default_nettype wire

/* File: wcfgt_top.sv */
// Washer timing: config registers, fill, drain, chemicals, restore
//
// Behaviour
// - Language code 0..6 held and driven to the display.
// - One bit picks cold or split fill for every finish step.
// - After drain opens, wait drain delay, then command extract.
// - Drain delay write accepted only within 30..255 seconds.
// - Low level still present at drain expiry raises drain error.
// - Fill timeout holds minutes 0..20; other values refused.
// - Nonzero fill timeout expiry closes valves, turns alert on.
// - Operator acknowledge reopens valves and restarts fill timer.
// - Zero timeout: valves stay open, alert after 10 minutes.
// - Chemicals 2..5 run fixed 30 seconds; only chemical 1 varies.
// - Per-formula chemical 1 time 0..255 s; zero means none.
// - Chemical 1 on for exactly the running formula's time.
// - Every restore sets all chemical 1 times back to 30 s.
// - Option 0 loads formulas 1..10 and clears 11..30.
// - Option 1 loads formulas 1..10, leaves valid flags of 11..30 untouched.
// - On level reached all step chemicals asserted together.
// - Flush starts 20 s after injection ends, lasts 30 s.
`timescale 1ns/1ps
`default_nettype none
module wcfgt_top #(
  parameter int unsigned TICK_CYC = wcfgt_pkg::TICK_CYC
) (
  // Clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  // Avalon-MM slave
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // Machine inputs
  input  wire logic        low_level_i,
  input  wire logic        level_ok_i,
  input  wire logic        op_ack_i,
  // Machine outputs
  output logic      [2:0]  lang_o,
  output logic             hot_valve_o,
  output logic             cold_valve_o,
  output logic             drain_o,
  output logic             extract_o,
  output logic             drain_err_o,
  output logic             alert_o,
  output logic      [4:0]  chem_o,
  output logic             flush_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic f_tick_hit(
    input logic [10:0] cnt,
    input logic [10:0] lim
  );
    f_tick_hit = (cnt + 11'h001) >= lim;
  endfunction : f_tick_hit

  function automatic logic [10:0] f_min2s(input logic [4:0] m);
    f_min2s = {m, 6'h00} - {4'h0, m, 2'h0};
  endfunction : f_min2s

  ////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic [31:0] tick_cnt_q;
  logic        tick_q;
  logic [2:0]  lang_q;
  logic        split_q;
  logic [7:0]  drain_dly_q;
  logic [4:0]  fillt_q;
  logic [4:0]  form_q;
  logic [4:0]  csel_q;
  logic [7:0]  c1_time_q [wcfgt_pkg::N_FORM];
  logic [29:0] valid_q;
  localparam int NS = wcfgt_pkg::NSTS;
  logic [NS-1:0] sts_q;
  logic [NS-1:0] msk_q;
  logic [4:0]  chem_req_q;
  logic [1:0]  temp_q;
  wcfgt_pkg::wcfgt_fill_t  fst_q;
  wcfgt_pkg::wcfgt_drain_t dst_q;
  wcfgt_pkg::wcfgt_flush_t lst_q;
  logic [10:0] fsec_q;
  logic [7:0]  dsec_q;
  logic [7:0]  c1_cnt_q;
  logic [7:0]  cx_cnt_q;
  logic [7:0]  lcnt_q;
  logic        flong_q;
  logic        chem_any_q;

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  logic req;
  logic acc;
  logic wr;
  logic rd_sts;
  assign req    = read_i | write_i;
  assign acc    = req & ~waitrequest_o;
  assign wr     = write_i & acc;
  assign rd_sts = read_i & acc & (address_i == wcfgt_pkg::A_STS);

  logic w_cfg;
  logic w_drn;
  logic w_flt;
  logic w_frm;
  logic w_csl;
  logic w_ctm;
  logic w_cmd;
  logic w_msk;
  logic w_rst;
  assign w_cfg = wr & (address_i == wcfgt_pkg::A_CFG);
  assign w_drn = wr & (address_i == wcfgt_pkg::A_DRAIN);
  assign w_flt = wr & (address_i == wcfgt_pkg::A_FILLT);
  assign w_frm = wr & (address_i == wcfgt_pkg::A_FORM);
  assign w_csl = wr & (address_i == wcfgt_pkg::A_CSEL);
  assign w_ctm = wr & (address_i == wcfgt_pkg::A_CTIM);
  assign w_cmd = wr & (address_i == wcfgt_pkg::A_CMD);
  assign w_msk = wr & (address_i == wcfgt_pkg::A_MSK);
  assign w_rst = wr & (address_i == wcfgt_pkg::A_RSTR);

  // Out-of-range values are dropped, old setting kept
  logic ok_lang;
  logic ok_drn;
  logic ok_flt;
  logic ok_frm;
  logic ok_csl;
  assign ok_lang = writedata_i[2:0] <= wcfgt_pkg::LANG_MAX;
  assign ok_drn  = (writedata_i[31:8] == 24'h000000)
                 & (writedata_i[7:0] >= wcfgt_pkg::DRAIN_MIN);
  assign ok_flt  = (writedata_i[31:5] == 27'h0000000)
                 & (writedata_i[4:0] <= wcfgt_pkg::FILLT_MAX);
  assign ok_frm  = writedata_i[4:0] < 5'(wcfgt_pkg::N_FORM);
  assign ok_csl  = ok_frm;

  logic cmd_drain;
  logic cmd_stopd;
  logic cmd_fill;
  logic cmd_stopf;
  assign cmd_drain = w_cmd & writedata_i[wcfgt_pkg::C_DRAIN];
  assign cmd_stopd = w_cmd & writedata_i[wcfgt_pkg::C_STOPD];
  assign cmd_fill  = w_cmd & writedata_i[wcfgt_pkg::C_FILL];
  assign cmd_stopf = w_cmd & writedata_i[wcfgt_pkg::C_STOPF];

  // Finish steps take cold or split from the config bit
  logic [1:0] temp_new;
  assign temp_new = writedata_i[wcfgt_pkg::C_FIN]
                  ? (split_q ? wcfgt_pkg::T_SPLIT : wcfgt_pkg::T_COLD)
                  : writedata_i[wcfgt_pkg::C_TEMP +: 2];

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h00000000;
    unique case (address_i)
      wcfgt_pkg::A_CFG:   rdata = {27'h0, split_q, 1'b0, lang_q};
      wcfgt_pkg::A_DRAIN: rdata = {24'h0, drain_dly_q};
      wcfgt_pkg::A_FILLT: rdata = {27'h0, fillt_q};
      wcfgt_pkg::A_FORM:  rdata = {27'h0, form_q};
      wcfgt_pkg::A_CSEL:  rdata = {27'h0, csel_q};
      wcfgt_pkg::A_CTIM:  rdata = {24'h0, c1_time_q[csel_q]};
      wcfgt_pkg::A_STS:   rdata = {25'h0, sts_q};
      wcfgt_pkg::A_MSK:   rdata = {25'h0, msk_q};
      wcfgt_pkg::A_STATE: rdata = {20'h0, flush_o, chem_o,
                                   lst_q, dst_q, fst_q};
      wcfgt_pkg::A_VALID: rdata = {2'h0, valid_q};
      default:            rdata = 32'h00000000;
    endcase
  end

  // One wait state: data latched, then waitrequest drops one cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h00000000;
    end else if (ce_i) begin
      waitrequest_o <= ~(req & waitrequest_o);
      if (req & waitrequest_o) begin
        readdata_o <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Second tick, restarted at injection start so pulses are exact

  logic chem_fire;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h00000000;
      tick_q     <= 1'b0;
    end else if (ce_i) begin
      tick_q     <= ~chem_fire & (tick_cnt_q == TICK_CYC - 1);
      // Restart one count ahead so an N second pulse is N ticks long
      tick_cnt_q <= chem_fire ? 32'h00000001
                  : (tick_cnt_q == TICK_CYC - 1) ? 32'h00000000
                  : tick_cnt_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lang_q      <= wcfgt_pkg::LANG_RST;
      split_q     <= 1'b0;
      drain_dly_q <= wcfgt_pkg::DRAIN_RST;
      fillt_q     <= wcfgt_pkg::FILLT_RST;
      form_q      <= 5'h00;
      csel_q      <= 5'h00;
      msk_q       <= '0;
    end else if (ce_i) begin
      if (w_cfg & ok_lang) begin
        lang_q  <= writedata_i[2:0];
      end
      if (w_cfg) begin
        split_q <= writedata_i[wcfgt_pkg::CFG_SPLIT];
      end
      if (w_drn & ok_drn) begin
        drain_dly_q <= writedata_i[7:0];
      end
      if (w_flt & ok_flt) begin
        fillt_q <= writedata_i[4:0];
      end
      if (w_frm & ok_frm) begin
        form_q <= writedata_i[4:0];
      end
      if (w_csl & ok_csl) begin
        csel_q <= writedata_i[4:0];
      end
      if (w_msk) begin
        msk_q <= writedata_i[NS-1:0];
      end
    end
  end

  // Formula store; restore completes in one cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < wcfgt_pkg::N_FORM; i++) begin
        c1_time_q[i] <= wcfgt_pkg::CHEM1_DFLT;
      end
      valid_q <= '0;
    end else if (ce_i) begin
      if (w_rst) begin
        for (int i = 0; i < wcfgt_pkg::N_FORM; i++) begin
          c1_time_q[i] <= wcfgt_pkg::CHEM1_DFLT;
          if (i < wcfgt_pkg::N_DFLT) begin
            valid_q[i] <= 1'b1;
          end else if (!writedata_i[0]) begin
            valid_q[i] <= 1'b0;
          end
        end
      end else if (w_ctm) begin
        c1_time_q[csel_q] <= writedata_i[7:0];
        valid_q[csel_q]   <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fill sequencer

  logic [10:0] fill_lim;
  logic        tmo_zero;
  logic        fill_done;
  assign tmo_zero  = fillt_q == 5'h00;
  assign fill_lim  = tmo_zero ? wcfgt_pkg::FILL_ZERO_S
                              : f_min2s(fillt_q);
  assign fill_done = (fst_q == wcfgt_pkg::F_RUN) & level_ok_i;
  assign chem_fire = fill_done & ~cmd_stopf;

  logic ev_ftmo;
  logic ev_flong;
  assign ev_ftmo  = (fst_q == wcfgt_pkg::F_RUN) & ~level_ok_i
                  & tick_q & ~tmo_zero & f_tick_hit(fsec_q, fill_lim);
  assign ev_flong = (fst_q == wcfgt_pkg::F_RUN) & ~level_ok_i
                  & tick_q & tmo_zero & ~flong_q
                  & f_tick_hit(fsec_q, fill_lim);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fst_q   <= wcfgt_pkg::F_IDLE;
      fsec_q  <= 11'h000;
      flong_q <= 1'b0;
      temp_q  <= 2'h0;
    end else if (ce_i) begin
      unique case (fst_q)
        wcfgt_pkg::F_IDLE: begin
          if (cmd_fill) begin
            fst_q   <= wcfgt_pkg::F_RUN;
            temp_q  <= temp_new;
            fsec_q  <= 11'h000;
            flong_q <= 1'b0;
          end
        end
        wcfgt_pkg::F_RUN: begin
          if (cmd_stopf | level_ok_i) begin
            fst_q <= wcfgt_pkg::F_IDLE;
          end else if (ev_ftmo) begin
            fst_q <= wcfgt_pkg::F_ERR;
          end else if (ev_flong) begin
            flong_q <= 1'b1;
          end else if (op_ack_i & flong_q) begin
            flong_q <= 1'b0;
            fsec_q  <= 11'h000;
          end else if (tick_q & ~flong_q) begin
            fsec_q <= fsec_q + 11'h001;
          end
        end
        wcfgt_pkg::F_ERR: begin
          if (cmd_stopf) begin
            fst_q <= wcfgt_pkg::F_IDLE;
          end else if (op_ack_i) begin
            fst_q  <= wcfgt_pkg::F_RUN;
            fsec_q <= 11'h000;
          end
        end
        default: fst_q <= wcfgt_pkg::F_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Drain sequencer

  logic drn_exp;
  assign drn_exp = (dst_q == wcfgt_pkg::D_WAIT) & tick_q
                 & f_tick_hit({3'h0, dsec_q}, {3'h0, drain_dly_q});

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dst_q  <= wcfgt_pkg::D_IDLE;
      dsec_q <= 8'h00;
    end else if (ce_i) begin
      if (cmd_stopd) begin
        dst_q <= wcfgt_pkg::D_IDLE;
      end else if (cmd_drain) begin
        dst_q  <= wcfgt_pkg::D_WAIT;
        dsec_q <= 8'h00;
      end else if (drn_exp) begin
        dst_q <= wcfgt_pkg::D_XTR;
      end else if ((dst_q == wcfgt_pkg::D_WAIT) & tick_q) begin
        dsec_q <= dsec_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Chemical injection and manifold flush

  logic [7:0] c1_run;
  logic [4:0] chem_d;
  logic       chem_any_d;
  assign c1_run = c1_time_q[form_q];
  assign chem_any_d = |chem_d;

  always_comb begin
    chem_d = chem_o;
    if (tick_q & (c1_cnt_q == 8'h01)) begin
      chem_d[0] = 1'b0;
    end
    if (tick_q & (cx_cnt_q == 8'h01)) begin
      chem_d[4:1] = 4'h0;
    end
    if (chem_fire) begin
      chem_d[0]   = chem_req_q[0] & (c1_run != 8'h00);
      chem_d[4:1] = chem_req_q[4:1];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chem_req_q <= 5'h00;
      c1_cnt_q   <= 8'h00;
      cx_cnt_q   <= 8'h00;
      chem_any_q <= 1'b0;
    end else if (ce_i) begin
      chem_any_q <= chem_any_d;
      if (cmd_fill) begin
        chem_req_q <= writedata_i[wcfgt_pkg::C_CHEM +: 5];
      end
      if (chem_fire) begin
        c1_cnt_q <= c1_run;
        cx_cnt_q <= wcfgt_pkg::CHEM_FIX_S;
      end else if (tick_q) begin
        c1_cnt_q <= (c1_cnt_q == 8'h00) ? 8'h00 : c1_cnt_q - 8'h01;
        cx_cnt_q <= (cx_cnt_q == 8'h00) ? 8'h00 : cx_cnt_q - 8'h01;
      end
    end
  end

  // A new injection while flushing restarts the flush cycle
  logic inj_end;
  logic flush_end;
  assign inj_end   = chem_any_q & ~chem_any_d;
  assign flush_end = (lst_q == wcfgt_pkg::L_ON) & tick_q
                   & (lcnt_q == 8'h01);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lst_q  <= wcfgt_pkg::L_IDLE;
      lcnt_q <= 8'h00;
    end else if (ce_i) begin
      if (inj_end) begin
        lst_q  <= wcfgt_pkg::L_DLY;
        lcnt_q <= wcfgt_pkg::FLUSH_DLY_S;
      end else if (chem_any_d) begin
        lst_q <= wcfgt_pkg::L_IDLE;
      end else if (tick_q & (lcnt_q == 8'h01)) begin
        lst_q  <= (lst_q == wcfgt_pkg::L_DLY)
                ? wcfgt_pkg::L_ON : wcfgt_pkg::L_IDLE;
        lcnt_q <= wcfgt_pkg::FLUSH_ON_S;
      end else if (tick_q & (lcnt_q != 8'h00)) begin
        lcnt_q <= lcnt_q - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status, interrupt, outputs

  logic [NS-1:0] ev;
  logic          derr_ev;
  assign derr_ev         = drn_exp & ~cmd_stopd & ~cmd_drain
                         & low_level_i;
  assign ev[wcfgt_pkg::S_DERR]  = derr_ev;
  assign ev[wcfgt_pkg::S_FTMO]  = ev_ftmo & ~cmd_stopf;
  assign ev[wcfgt_pkg::S_FLONG] = ev_flong & ~cmd_stopf;
  assign ev[wcfgt_pkg::S_FDONE] = chem_fire;
  assign ev[wcfgt_pkg::S_XTR]   = drn_exp & ~cmd_stopd & ~cmd_drain;
  assign ev[wcfgt_pkg::S_FLUSH] = flush_end;
  assign ev[wcfgt_pkg::S_RSTR]  = w_rst;

  // Set beats the read-clear in the same cycle
  logic [NS-1:0] sts_d;
  // Only bits the read returned are cleared, so no event is lost
  assign sts_d = (sts_q & ~({NS{rd_sts}} & readdata_o[NS-1:0])) | ev;

  logic alert_d;
  assign alert_d = (fst_q == wcfgt_pkg::F_ERR) & ~op_ack_i
                 & ~cmd_stopf
                 | ev_ftmo & ~cmd_stopf
                 | (fst_q == wcfgt_pkg::F_RUN) & ~level_ok_i
                 & ~cmd_stopf & ~op_ack_i
                 & (flong_q | ev_flong);

  logic valve_d;
  assign valve_d = (fst_q == wcfgt_pkg::F_RUN) & ~level_ok_i
                 & ~cmd_stopf & ~ev_ftmo
                 | (fst_q == wcfgt_pkg::F_ERR) & op_ack_i
                 & ~cmd_stopf
                 | (fst_q == wcfgt_pkg::F_IDLE) & cmd_fill;

  logic [1:0] temp_d;
  assign temp_d = (fst_q == wcfgt_pkg::F_IDLE) ? temp_new : temp_q;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sts_q        <= '0;
      irq_o        <= 1'b0;
      lang_o       <= wcfgt_pkg::LANG_RST;
      hot_valve_o  <= 1'b0;
      cold_valve_o <= 1'b0;
      drain_o      <= 1'b0;
      extract_o    <= 1'b0;
      drain_err_o  <= 1'b0;
      alert_o      <= 1'b0;
      chem_o       <= 5'h00;
      flush_o      <= 1'b0;
    end else if (ce_i) begin
      sts_q        <= sts_d;
      irq_o        <= |(sts_d & msk_q);
      lang_o       <= (w_cfg & ok_lang) ? writedata_i[2:0] : lang_q;
      hot_valve_o  <= valve_d & temp_d[0];
      cold_valve_o <= valve_d & temp_d[1];
      drain_o      <= ~cmd_stopd & (cmd_drain
                    | (dst_q != wcfgt_pkg::D_IDLE));
      extract_o    <= ~cmd_stopd & ~cmd_drain
                    & ((dst_q == wcfgt_pkg::D_XTR) | drn_exp);
      drain_err_o  <= ~cmd_stopd & ~cmd_drain
                    & (drain_err_o | derr_ev);
      alert_o      <= alert_d;
      chem_o       <= chem_d;
      flush_o      <= ~inj_end & ~chem_any_d
                    & ((lst_q == wcfgt_pkg::L_ON) & ~flush_end
                    | (lst_q == wcfgt_pkg::L_DLY) & tick_q
                    & (lcnt_q == 8'h01));
    end
  end

  // Pulse length on chemical 1 is the formula code for the supplier

endmodule : wcfgt_top
`default_nettype wire
